// File: rtl/inquiry_regs.svh
// constants shared by the target and initiator ends of the inquiry link
// assumes byte-wide link transfers and a 32-bit wishbone on the initiator
`ifndef INQUIRY_REGS_SVH
`define INQUIRY_REGS_SVH
`define OP_INQUIRY 8'h12
`define OP_FORMAT 8'h04
`define CDB_LEN 3'h6
`define DLF_PHYS 3'h5
`define FMT_DATA_BIT 4
`define VPD_SEL_BIT 0
`define PRIMARY_LIST_DISREGARD_BIT 6
`define HDR_LEN 16'h0004
`define PERIPH_BYTE0 8'h00
`define STD_LEN 16'h00a4
`define STD_PART_LEN 16'h0024
`define STD_ADDL 8'h9f
`define VPD_LIST 8'h00
`define VPD_VAR 8'h03
`define VPD_SERIAL 8'h80
`define VPD_LIST_LEN 16'h0007
`define VPD_VAR_LEN 16'h0008
`define VPD_SERIAL_LEN 16'h000c
`define SK_ILLEGAL 4'h5
`define SK_UA 4'h6
`define ASC_BAD_CDB 8'h24
`define ASC_BAD_PARAM 8'h26
`define ASC_UA 8'h29
`define REG_CTRL 8'h00
`define REG_CDB_LO 8'h04
`define REG_CDB_HI 8'h08
`define REG_PLEN 8'h0c
`define REG_STATUS 8'h10
`define REG_RXCNT 8'h14
`define REG_RX_BASE 8'h40
`define REG_PAR_BASE 8'h80
`endif

// File: rtl/inquiry_pkg.sv
// state types for both ends of the inquiry link
// assumes nothing beyond a SystemVerilog package scope
`default_nettype none
package inquiry_pkg;
	typedef enum logic [5:0] {
		TS_CMD = 6'b000001,
		TS_DECODE = 6'b000010,
		TS_DATAIN = 6'b000100,
		TS_DOUT = 6'b001000,
		TS_CHECK = 6'b010000,
		TS_STATUS = 6'b100000
	} target_state_t;
	typedef enum logic [3:0] {
		HS_IDLE = 4'b0001,
		HS_CMD = 4'b0010,
		HS_DOUT = 4'b0100,
		HS_WAIT = 4'b1000
	} host_state_t;
endpackage : inquiry_pkg
`default_nettype wire

// File: rtl/inquiry_link_if.sv
// byte link between an initiator and a storage target
// assumes both ends share one clock; h_data transfers on h_valid and d_ready high, d_data on d_valid alone
`default_nettype none
interface inquiry_link_if (
	input wire logic clk
);
	logic h_valid;
	logic [7:0] h_data;
	logic d_ready;
	logic d_valid;
	logic [7:0] d_data;
	logic s_valid;
	logic s_check;
	logic [3:0] s_key;
	logic [7:0] s_asc;
	modport target (input h_valid, h_data, output d_ready, d_valid, d_data,
		s_valid, s_check, s_key, s_asc);
	modport initiator (output h_valid, h_data, input d_ready, d_valid, d_data,
		s_valid, s_check, s_key, s_asc);
endinterface : inquiry_link_if
`default_nettype wire

// File: rtl/inquiry_target.sv
// storage target end: inquiry execution and physical-sector defect parsing
// assumes the initiator takes every data-in byte in the cycle it is shown
//
// Behaviour
// - physical descriptor: 3 cylinder, 1 head, 4 sector
// - each descriptor names one defective sector
// - skip primary-list match when disregard bit set (code checks the primary list only when the bit is set)
// - opcode 12h is inquiry
// - byte1 bit0 vital select, byte2 page code
// - select clear, page zero: standard data
// - select clear, page nonzero: invalid field CDB
// - select set: return requested vital page
// - bytes 3-4 hold allocation length
// - zero allocation length sends no data
// - send smaller of available and allocation length
// - inquiry runs, pending unit attention kept
// - inquiry executed directly, never queued
// - data fixed except microcode revision level
// - vital page 3 contents may vary
// - media unavailable gives incomplete data
// - first byte same for every page
// - qualifier zero, device type direct access
// - character fields hold ASCII codes
// - bad descriptor location: invalid field parameter list
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`include "inquiry_regs.svh"
`default_nettype none
module inquiry_target #(
	parameter int PLIST_DEPTH = 8,
	parameter logic [63:0] VENDOR_ID = 64'h56454e444f522020, // arbitrary
	parameter logic [127:0] PRODUCT_ID = {32'h4449534b, {12{8'h20}}}, // arbitrary
	parameter logic [63:0] SERIAL_NO = 64'h3030303030303031 // arbitrary
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// link to initiator
	inquiry_link_if.target link,
	// device context
	input wire logic i_media_ready,
	input wire logic [31:0] i_revision,
	input wire logic [31:0] i_vpd3_word,
	input wire logic i_unit_attention,
	// primary defect list load and geometry
	input wire logic i_plist_we,
	input wire logic [$clog2(PLIST_DEPTH)-1:0] i_plist_idx,
	input wire logic [63:0] i_plist_entry,
	input wire logic [23:0] i_max_cyl,
	input wire logic [7:0] i_max_head,
	input wire logic [31:0] i_max_sector,
	// grown list, command queue and attention
	output logic o_glist_add,
	output logic [63:0] o_defect,
	output logic o_queue_push,
	output logic [7:0] o_queue_opcode,
	output logic o_ua_clear
);
	inquiry_pkg::target_state_t state, next_state;
	logic [7:0] cdb [0:5];
	logic [2:0] ccnt;
	logic [15:0] idx;
	logic [15:0] xfer_len, next_len, avail, alloc_len;
	logic [15:0] pcnt, plen;
	logic primary_list_disregard;
	logic [63:0] desc;
	logic [63:0] plist [0:PLIST_DEPTH-1];
	logic [PLIST_DEPTH-1:0] plist_ok;
	logic plist_hit, desc_ok, take, vpd_sel, page_ok, set_err;
	logic [3:0] next_key;
	logic [7:0] next_asc, page;

	assign take = link.h_valid && link.d_ready;
	assign vpd_sel = cdb[1][`VPD_SEL_BIT];
	assign page = cdb[2];
	assign alloc_len = {cdb[3], cdb[4]};
	assign desc_ok = desc[63:40] <= i_max_cyl && desc[39:32] <= i_max_head
		&& desc[31:0] <= i_max_sector;

	// inquiry response bytes; revision is live so a microcode load shows up
	function automatic logic [7:0] resp_byte(input logic [15:0] i);
		logic [7:0] b;
		logic [63:0] s;
		logic [127:0] p;
		b = 8'h00;
		s = SERIAL_NO << {i[2:0] ^ 3'h4, 3'h0};
		p = PRODUCT_ID << {i[3:0], 3'h0};
		if (i == 16'h0000) begin
			b = `PERIPH_BYTE0;
		end else if (!vpd_sel) begin
			unique case (1'b1)
				i == 16'h0002: b = 8'h06;
				i == 16'h0003: b = 8'h12;
				i == 16'h0004: b = `STD_ADDL;
				i == 16'h0005: b = 8'h01;
				i == 16'h0006: b = 8'h10;
				i == 16'h0007: b = 8'h02;
				i >= 16'h0008 && i <= 16'h000f: b = VENDOR_ID[8*(15-i[3:0]) +: 8];
				i >= 16'h0010 && i <= 16'h001f: b = p[127:120];
				i >= 16'h0020 && i <= 16'h0023: b = i_revision[8*(3-i[1:0]) +: 8];
				i >= 16'h0024 && i <= 16'h002b: b = s[63:56];
				i >= 16'h0060 && i <= 16'h0091: b = 8'h20;
				default: b = 8'h00;
			endcase
		end else if (i == 16'h0001) begin
			b = page;
		end else if (i == 16'h0003) begin
			b = 8'(avail - `HDR_LEN);
		end else if (i >= `HDR_LEN) begin
			unique case (page)
				`VPD_LIST: b = i[1:0] == 2'h0 ? `VPD_LIST : (i[1:0] == 2'h1 ? `VPD_VAR : `VPD_SERIAL);
				`VPD_VAR: b = i_vpd3_word[8*(3-i[1:0]) +: 8];
				default: b = s[63:56];
			endcase
		end
		return b;
	endfunction : resp_byte

	always_comb begin
		page_ok = page == `VPD_LIST || page == `VPD_VAR || page == `VPD_SERIAL;
		if (!vpd_sel) begin
			avail = i_media_ready ? `STD_LEN : `STD_PART_LEN;
		end else begin
			unique case (page)
				`VPD_LIST: avail = `VPD_LIST_LEN;
				`VPD_VAR: avail = `VPD_VAR_LEN;
				default: avail = `VPD_SERIAL_LEN;
			endcase
		end
		next_len = alloc_len < avail ? alloc_len : avail;
	end

	assign plist_hit = |plist_ok && primary_list_disregard;

	always_comb begin
		next_state = state;
		set_err = 1'b0;
		next_key = `SK_ILLEGAL;
		next_asc = `ASC_BAD_CDB;
		unique case (state)
			inquiry_pkg::TS_CMD: begin
				if (take && ccnt == `CDB_LEN - 3'h1) next_state = inquiry_pkg::TS_DECODE;
			end
			inquiry_pkg::TS_DECODE: begin
				next_state = inquiry_pkg::TS_STATUS;
				if (cdb[0] == `OP_INQUIRY) begin
					if ((!vpd_sel && page != 8'h00) || (vpd_sel && !page_ok)) begin
						set_err = 1'b1;
					end else if (next_len != 16'h0000) begin
						next_state = inquiry_pkg::TS_DATAIN;
					end
				end else if (cdb[0] == `OP_FORMAT && cdb[1][`FMT_DATA_BIT]) begin
					if (cdb[1][2:0] != `DLF_PHYS) set_err = 1'b1;
					else next_state = inquiry_pkg::TS_DOUT;
				end else if (cdb[0] != `OP_FORMAT && i_unit_attention) begin
					set_err = 1'b1;
					next_key = `SK_UA;
					next_asc = `ASC_UA;
				end
			end
			inquiry_pkg::TS_DATAIN: begin
				if (idx == xfer_len - 16'h0001) next_state = inquiry_pkg::TS_STATUS;
			end
			inquiry_pkg::TS_DOUT: begin
				next_asc = `ASC_BAD_PARAM;
				if (take && pcnt == `HDR_LEN - 16'h0001) begin
					if (link.h_data[2:0] != 3'h0) set_err = 1'b1;
					if ({plen[15:8], link.h_data} == 16'h0000 || link.h_data[2:0] != 3'h0)
						next_state = inquiry_pkg::TS_STATUS;
				end else if (take && pcnt >= `HDR_LEN && pcnt[2:0] == 3'h3) begin
					next_state = inquiry_pkg::TS_CHECK;
				end
			end
			inquiry_pkg::TS_CHECK: begin
				next_asc = `ASC_BAD_PARAM;
				next_state = inquiry_pkg::TS_DOUT;
				if (!desc_ok) set_err = 1'b1;
				if (!desc_ok || pcnt == `HDR_LEN + plen) next_state = inquiry_pkg::TS_STATUS;
			end
			inquiry_pkg::TS_STATUS: next_state = inquiry_pkg::TS_CMD;
			default: next_state = inquiry_pkg::TS_CMD;
		endcase
		if (set_err) next_state = inquiry_pkg::TS_STATUS;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) state <= inquiry_pkg::TS_CMD;
		else state <= next_state;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			ccnt <= 3'h0;
		end else if (state == inquiry_pkg::TS_CMD && take) begin
			cdb[ccnt] <= link.h_data;
			ccnt <= ccnt == `CDB_LEN - 3'h1 ? 3'h0 : ccnt + 3'h1;
		end
	end

	// parameter data: header then eight-byte descriptors, msb first
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || state == inquiry_pkg::TS_DECODE) begin
			pcnt <= 16'h0000;
			plen <= 16'h0000;
			primary_list_disregard <= 1'b0;
		end else if (state == inquiry_pkg::TS_DOUT && take) begin
			pcnt <= pcnt + 16'h0001;
			if (pcnt == 16'h0001) primary_list_disregard <= link.h_data[`PRIMARY_LIST_DISREGARD_BIT];
			if (pcnt == 16'h0002) plen[15:8] <= link.h_data;
			if (pcnt == 16'h0003) plen[7:0] <= link.h_data;
			if (pcnt >= `HDR_LEN) desc <= {desc[55:0], link.h_data};
		end
	end

	generate
		for (genvar g = 0; g < PLIST_DEPTH; g++) begin : g_plist
			assign plist_ok[g] = plist[g] == desc;
		end
	endgenerate

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			for (int k = 0; k < PLIST_DEPTH; k++) plist[k] <= {64{1'b1}};
		end else if (i_plist_we) begin
			plist[i_plist_idx] <= i_plist_entry;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_glist_add <= 1'b0;
			o_defect <= 64'h0;
		end else begin
			o_glist_add <= state == inquiry_pkg::TS_CHECK && desc_ok && !plist_hit;
			if (state == inquiry_pkg::TS_CHECK) o_defect <= desc;
		end
	end

	// only non-inquiry commands touch the queue or the pending attention
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_queue_push <= 1'b0;
			o_queue_opcode <= 8'h00;
			o_ua_clear <= 1'b0;
		end else begin
			o_queue_push <= state == inquiry_pkg::TS_DECODE && cdb[0] != `OP_INQUIRY
				&& cdb[0] != `OP_FORMAT && !i_unit_attention;
			o_ua_clear <= state == inquiry_pkg::TS_DECODE && cdb[0] != `OP_INQUIRY
				&& cdb[0] != `OP_FORMAT && i_unit_attention;
			if (state == inquiry_pkg::TS_DECODE) o_queue_opcode <= cdb[0];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			idx <= 16'h0000;
			xfer_len <= 16'h0000;
			link.d_valid <= 1'b0;
			link.d_data <= 8'h00;
		end else begin
			link.d_valid <= state == inquiry_pkg::TS_DATAIN;
			if (state == inquiry_pkg::TS_DECODE) begin
				idx <= 16'h0000;
				xfer_len <= next_len;
			end else if (state == inquiry_pkg::TS_DATAIN) begin
				link.d_data <= resp_byte(idx);
				idx <= idx + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			link.d_ready <= 1'b0;
			link.s_valid <= 1'b0;
			link.s_check <= 1'b0;
			link.s_key <= 4'h0;
			link.s_asc <= 8'h00;
		end else begin
			// low while status shows, so a stale parameter byte is never taken as a command
			link.d_ready <= (next_state == inquiry_pkg::TS_CMD && state != inquiry_pkg::TS_STATUS)
				|| next_state == inquiry_pkg::TS_DOUT;
			link.s_valid <= state == inquiry_pkg::TS_STATUS;
			if (state == inquiry_pkg::TS_DECODE) begin
				link.s_check <= 1'b0;
				link.s_key <= 4'h0;
				link.s_asc <= 8'h00;
			end
			if (set_err) begin
				link.s_check <= 1'b1;
				link.s_key <= next_key;
				link.s_asc <= next_asc;
			end
		end
	end
endmodule : inquiry_target
`default_nettype wire

// File: rtl/inquiry_initiator.sv
// initiator end: software builds a command over wishbone and reads results
// assumes the target drops ready whenever it cannot take a byte
`include "inquiry_regs.svh"
`default_nettype none
module inquiry_initiator (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// link to target
	inquiry_link_if.initiator link
);
	inquiry_pkg::host_state_t state;
	logic [7:0] cdb [0:5];
	logic [7:0] par [0:63];
	logic [7:0] rx [0:63];
	logic [7:0] plen, rxcnt, bidx;
	logic done, chk;
	logic [3:0] key;
	logic [7:0] asc;
	logic wr, rd_req, take, start;

	// writes land at the edge where the master sees ack high
	assign wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
	assign rd_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign take = link.h_valid && link.d_ready;
	assign start = wr && i_wb_adr == `REG_CTRL && i_wb_dat[0] && state == inquiry_pkg::HS_IDLE;

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			plen <= 8'h00;
		end else if (wr) begin
			for (int b = 0; b < 4; b++) begin
				if (i_wb_sel[b]) begin
					if (i_wb_adr == `REG_CDB_LO) cdb[b] <= i_wb_dat[8*b +: 8];
					if (i_wb_adr == `REG_CDB_HI && b < 2) cdb[b+4] <= i_wb_dat[8*b +: 8];
					if (i_wb_adr == `REG_PLEN && b == 0) plen <= i_wb_dat[7:0] > 8'h40 ? 8'h40 : i_wb_dat[7:0];
					if (i_wb_adr[7:6] == 2'h2) par[{i_wb_adr[5:2], 2'(b)}] <= i_wb_dat[8*b +: 8];
				end
			end
		end
	end

	// read data registered one cycle after the strobe, with ack
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
		end else begin
			o_wb_ack <= rd_req;
			o_wb_dat <= 32'h0;
			if (rd_req && !i_wb_we) begin
				if (i_wb_adr == `REG_STATUS)
					o_wb_dat <= {8'h00, asc, 4'h0, key, 5'h0, chk, done, state != inquiry_pkg::HS_IDLE};
				else if (i_wb_adr == `REG_RXCNT) o_wb_dat <= {24'h0, rxcnt};
				else if (i_wb_adr == `REG_PLEN) o_wb_dat <= {24'h0, plen};
				else if (i_wb_adr[7:6] == 2'h1)
					o_wb_dat <= {rx[{i_wb_adr[5:2], 2'h3}], rx[{i_wb_adr[5:2], 2'h2}],
						rx[{i_wb_adr[5:2], 2'h1}], rx[{i_wb_adr[5:2], 2'h0}]};
			end
		end
	end

	// a status from the target ends the command even mid-transfer
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			state <= inquiry_pkg::HS_IDLE;
			link.h_valid <= 1'b0;
			link.h_data <= 8'h00;
			bidx <= 8'h00;
		end else if (start) begin
			state <= inquiry_pkg::HS_CMD;
			link.h_valid <= 1'b1;
			link.h_data <= cdb[0];
			bidx <= 8'h01;
		end else if (link.s_valid) begin
			state <= inquiry_pkg::HS_IDLE;
			link.h_valid <= 1'b0;
		end else if (take) begin
			bidx <= bidx + 8'h01;
			if (state == inquiry_pkg::HS_CMD && bidx < 8'(`CDB_LEN)) begin
				link.h_data <= cdb[bidx[2:0]];
			end else if (state == inquiry_pkg::HS_CMD && plen != 8'h00) begin
				state <= inquiry_pkg::HS_DOUT;
				link.h_data <= par[0];
				bidx <= 8'h01;
			end else if (state == inquiry_pkg::HS_DOUT && bidx < plen) begin
				link.h_data <= par[bidx[5:0]];
			end else begin
				state <= inquiry_pkg::HS_WAIT;
				link.h_valid <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			rxcnt <= 8'h00;
			done <= 1'b0;
			chk <= 1'b0;
			key <= 4'h0;
			asc <= 8'h00;
		end else begin
			if (start) begin
				rxcnt <= 8'h00;
				done <= 1'b0;
			end else if (link.d_valid) begin
				if (rxcnt < 8'h40) rx[rxcnt[5:0]] <= link.d_data;
				rxcnt <= rxcnt == 8'hff ? rxcnt : rxcnt + 8'h01;
			end
			if (link.s_valid) begin
				done <= 1'b1;
				chk <= link.s_check;
				key <= link.s_key;
				asc <= link.s_asc;
			end
		end
	end
endmodule : inquiry_initiator
`default_nettype wire

// File: tb/inquiry_asserts.sv
// link checker for the inquiry initiator and target pair
// assumes one clock domain and a synchronous active-high reset
`default_nettype none
module inquiry_asserts (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// link signals
	input wire logic h_valid,
	input wire logic [7:0] h_data,
	input wire logic d_ready,
	input wire logic d_valid,
	input wire logic [7:0] d_data,
	input wire logic s_valid,
	input wire logic s_check,
	input wire logic [3:0] s_key,
	input wire logic [7:0] s_asc
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] idx;
	logic [7:0] op, b1, b2;
	logic [15:0] alloc, dcount;
	logic take, last_cdb, inq, page_ok;
	assign take = h_valid && d_ready;
	assign last_cdb = take && idx == 3'h5;
	assign inq = op == 8'h12;
	assign page_ok = b1[0] ? (b2 == 8'h00 || b2 == 8'h03 || b2 == 8'h80) : b2 == 8'h00;
	// saturates so parameter bytes never alias onto command byte slots
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || s_valid) begin
			idx <= 3'h0;
		end else if (take && idx != 3'h7) begin
			idx <= idx + 3'h1;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (take) begin
			case (idx)
				3'h0: op <= h_data;
				3'h1: b1 <= h_data;
				3'h2: b2 <= h_data;
				3'h3: alloc[15:8] <= h_data;
				3'h4: alloc[7:0] <= h_data;
				default: ;
			endcase
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || s_valid) begin
			dcount <= 16'h0;
		end else if (d_valid) begin
			dcount <= dcount + 16'h1;
		end
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	a_ready_drop: assert property (last_cdb |=> !d_ready)
		else $error("target kept ready after the last command byte");
	a_bad_page: assert property (last_cdb && inq && !b1[0] && b2 != 8'h00 |-> ##3
		(s_valid && s_check && s_key == 4'h5 && s_asc == 8'h24))
		else $error("page without vital select not refused");
	a_first_byte: assert property (last_cdb && inq && page_ok && alloc != 16'h0 |-> ##3
		(d_valid && d_data == 8'h00))
		else $error("first returned byte wrong or late");
	a_vpd_echo: assert property (last_cdb && inq && b1[0] && page_ok && alloc > 16'h1
		|-> ##4 (d_valid && d_data == b2))
		else $error("vital page code not echoed in byte one");
	a_zero_alloc: assert property (last_cdb && inq && page_ok && alloc == 16'h0
		|-> ##1 !d_valid ##1 !d_valid ##1 (s_valid && !s_check && !d_valid))
		else $error("data sent with zero allocation");
	a_alloc_cap: assert property (d_valid && inq |-> dcount < alloc)
		else $error("more bytes sent than allocated");
	a_burst_end: assert property ($fell(d_valid) |-> s_valid && !s_check)
		else $error("data burst not closed by good status");
	a_ua_runs: assert property (last_cdb && inq && page_ok |-> ##3 !(s_valid && s_check))
		else $error("valid inquiry ended in check condition");
	a_status_ready: assert property (s_valid |=> !s_valid ##1 d_ready)
		else $error("ready not back after status");
	a_sense_codes: assert property (s_valid && s_check |->
		(s_key == 4'h5 && (s_asc == 8'h24 || s_asc == 8'h26)) || (s_key == 4'h6 && s_asc == 8'h29))
		else $error("unexpected sense key or code");
endmodule : inquiry_asserts
`default_nettype wire

// File: tb/tb_inquiry_and_defect_parse.sv
// self-checking bench: initiator and target joined over the byte link
// assumes the initiator answers every wishbone request with one ack pulse
`include "inquiry_regs.svh"
`default_nettype none
module tb_inquiry_and_defect_parse;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk_sys, i_reset, wb_cyc, wb_stb, wb_we, wb_ack, media, ua, pl_we;
	logic glist_add, q_push, ua_clr;
	logic [3:0] wb_sel;
	logic [7:0] wb_adr, q_op;
	logic [12:0] stat;
	logic [31:0] wb_dat, wb_q, wb_rd, rev;
	logic [63:0] pl_entry, defect, last_defect;
	int fails = 0, compares = 0, n_data, n_glist, n_ua, n_push;
	inquiry_link_if inquiry_link_if_i (.clk(i_clk_sys));
	inquiry_target inquiry_target_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.link(inquiry_link_if_i.target), .i_media_ready(media), .i_revision(rev),
		.i_vpd3_word(32'h01020304), .i_unit_attention(ua), .i_plist_we(pl_we),
		.i_plist_idx(3'h0), .i_plist_entry(pl_entry), .i_max_cyl(24'h100000),
		.i_max_head(8'h0f), .i_max_sector(32'h0fffffff), .o_glist_add(glist_add),
		.o_defect(defect), .o_queue_push(q_push), .o_queue_opcode(q_op), .o_ua_clear(ua_clr));
	inquiry_initiator inquiry_initiator_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
		.i_wb_dat(wb_dat), .i_wb_sel(wb_sel), .o_wb_dat(wb_q), .o_wb_ack(wb_ack),
		.link(inquiry_link_if_i.initiator));
	inquiry_asserts inquiry_asserts_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.h_valid(inquiry_link_if_i.h_valid), .h_data(inquiry_link_if_i.h_data),
		.d_ready(inquiry_link_if_i.d_ready), .d_valid(inquiry_link_if_i.d_valid),
		.d_data(inquiry_link_if_i.d_data), .s_valid(inquiry_link_if_i.s_valid),
		.s_check(inquiry_link_if_i.s_check), .s_key(inquiry_link_if_i.s_key),
		.s_asc(inquiry_link_if_i.s_asc));
	always @(posedge i_clk_sys) begin
		if (inquiry_link_if_i.d_valid === 1'b1) n_data++;
		if (ua_clr === 1'b1) n_ua++;
		if (q_push === 1'b1) n_push++;
		if (glist_add === 1'b1) begin
			n_glist++;
			last_defect = defect;
		end
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim;
		if (fails == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat <= dat;
		wb_sel <= 4'hf;
		do @(posedge i_clk_sys); while (wb_ack !== 1'b1);
		wb_rd = wb_q;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge i_clk_sys);
	endtask : wb_cycle
	// command bytes go in low byte first; polls until idle with done set
	task automatic run_cmd(input logic [47:0] cdb, input logic [31:0] plen);
		n_data = 0;
		n_glist = 0;
		n_ua = 0;
		n_push = 0;
		wb_cycle(1'b1, `REG_CDB_LO, cdb[31:0]);
		wb_cycle(1'b1, `REG_CDB_HI, {16'h0, cdb[47:32]});
		wb_cycle(1'b1, `REG_PLEN, plen);
		wb_cycle(1'b1, `REG_CTRL, 32'h1);
		do wb_cycle(1'b0, `REG_STATUS, 32'h0); while (wb_rd[1:0] !== 2'b10);
		stat = {wb_rd[2], wb_rd[11:8], wb_rd[23:16]};
	endtask : run_cmd
	function automatic logic [47:0] inq(input logic vs, input logic [7:0] pg, input logic [15:0] al);
		return {8'h00, al[7:0], al[15:8], pg, 7'h0, vs, 8'h12};
	endfunction : inq
	task automatic t_standard;
		run_cmd(inq(1'b0, 8'h00, 16'd200), 32'h0);
		check(n_data, 164);
		check(stat, 13'h0);
		wb_cycle(1'b0, `REG_RX_BASE, 32'h0);
		check(wb_rd[7:0], 8'h00);
		rev <= 32'h41423031;
		run_cmd(inq(1'b0, 8'h00, 16'd36), 32'h0);
		wb_cycle(1'b0, 8'h60, 32'h0);
		check(wb_rd, 32'h31304241);
		media <= 1'b0;
		run_cmd(inq(1'b0, 8'h00, 16'd200), 32'h0);
		check(n_data, 36);
		media <= 1'b1;
	endtask : t_standard
	task automatic t_vpd;
		logic [7:0] pg [3] = '{8'h00, 8'h03, 8'h80};
		int len [3] = '{7, 8, 12};
		for (int k = 0; k < 3; k++) begin
			run_cmd(inq(1'b1, pg[k], 16'd255), 32'h0);
			check(n_data, len[k]);
			wb_cycle(1'b0, `REG_RX_BASE, 32'h0);
			check(wb_rd[15:0], {pg[k], 8'h00});
		end
		run_cmd(inq(1'b1, 8'h80, 16'd2), 32'h0);
		wb_cycle(1'b0, `REG_RXCNT, 32'h0);
		check(wb_rd, 32'h2);
	endtask : t_vpd
	task automatic t_errors;
		run_cmd(inq(1'b0, 8'h03, 16'd10), 32'h0);
		check(stat, {1'b1, 4'h5, 8'h24});
		check(n_data, 0);
		run_cmd(inq(1'b1, 8'h55, 16'd10), 32'h0);
		check(stat, {1'b1, 4'h5, 8'h24});
		run_cmd({32'h0, 8'h14, 8'h04}, 32'd12);
		check(stat, {1'b1, 4'h5, 8'h24});
		run_cmd(inq(1'b0, 8'h00, 16'd0), 32'h0);
		check(n_data, 0);
		check(stat, 13'h0);
	endtask : t_errors
	task automatic t_attention;
		ua <= 1'b1;
		run_cmd(inq(1'b0, 8'h00, 16'd4), 32'h0);
		check(n_data, 4);
		check(n_ua + n_push, 0);
		run_cmd(48'h2a, 32'h0);
		check(stat, {1'b1, 4'h6, 8'h29});
		check(n_ua, 1);
		ua <= 1'b0;
		run_cmd(48'h2a, 32'h0);
		check(n_push, 1);
		check(q_op, 8'h2a);
	endtask : t_attention
	// header, then one descriptor: cylinder and head from w1, sector 0789abcdh
	task automatic fmt(input logic [31:0] hdr, input logic [31:0] w1);
		wb_cycle(1'b1, `REG_PAR_BASE, hdr);
		wb_cycle(1'b1, 8'h84, w1);
		wb_cycle(1'b1, 8'h88, 32'hcdab8907);
		run_cmd({32'h0, 8'h15, 8'h04}, 32'd12);
	endtask : fmt
	task automatic t_format;
		fmt(32'h08000000, 32'h06452301);
		check(n_glist, 1);
		check(last_defect, 64'h012345060789abcd);
		check(stat, 13'h0);
		pl_entry <= 64'h012345060789abcd;
		pl_we <= 1'b1;
		@(posedge i_clk_sys);
		pl_we <= 1'b0;
		fmt(32'h08004000, 32'h06452301);
		check(n_glist, 0);
		fmt(32'h08000000, 32'h06ffffff);
		check(stat, {1'b1, 4'h5, 8'h26});
		check(n_glist, 0);
	endtask : t_format
	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	// roughly twenty commands of under two hundred cycles each fit well inside
	initial begin
		repeat (30000) @(posedge i_clk_sys);
		fails++;
		end_sim();
	end
	initial begin
		i_reset = 1'b1;
		{wb_cyc, wb_stb, wb_we, ua, pl_we} = 5'h0;
		{wb_adr, wb_sel, wb_dat, pl_entry} = '0;
		media = 1'b1;
		rev = 32'h30303030;
		repeat (2) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		@(posedge i_clk_sys);
		t_standard();
		t_vpd();
		t_errors();
		t_attention();
		t_format();
		end_sim();
	end
endmodule : tb_inquiry_and_defect_parse
`default_nettype wire
